// ===== rtl/sensor_bus_pkg.sv
// ****************************************************************
// Shared constants and types for the sensor bus slave.
// ****************************************************************
package sensor_bus_pkg;

   // Command codes seen by the slave.
   localparam logic [3:0] CMD_INIT = 4'h0;
   localparam logic [3:0] CMD_STATUS = 4'h1;
   localparam logic [3:0] CMD_ACCEL = 4'h2;
   localparam logic [3:0] CMD_NVM = 4'h9;
   localparam logic [3:0] CMD_FORMAT = 4'ha;
   localparam logic [3:0] CMD_REG_READ = 4'hb;
   localparam logic [3:0] CMD_ST_OFF = 4'hc;
   localparam logic [3:0] CMD_ST_ON = 4'hd;
   localparam logic [3:0] CMD_REV_INIT = 4'hf;

   // Addresses and fixed field values.
   localparam logic [3:0] GLOBAL_ADDR = 4'h0;
   localparam logic [3:0] NO_ADDR = 4'h0;
   localparam logic [1:0] ATTR_UNLOCKED = 2'b10;
   localparam logic [3:0] FORMAT_ECHO = 4'h6;
   localparam logic [3:0] BANK_VALID_MASK = 4'h7;

   // Check code generator.
   localparam logic [3:0] CRC_POLY = 4'h3;
   localparam logic [3:0] CRC_SEED = 4'ha;

   // Command data field positions.
   localparam int NV_POS = 7;
   localparam int BS_POS = 6;
   localparam int RW_POS = 7;

   // Format register file shape.
   localparam int FMT_WIDTH = 4;
   localparam int FMT_DEPTH = 8;

   // Bus voltage blanking after a switch closure request.
   localparam int CLOCK_PERIOD_NS = 20;
   localparam int BLANK_TIME_NS = 180000;
   localparam int BLANK_CYCLES = BLANK_TIME_NS / CLOCK_PERIOD_NS;
   localparam int BLANK_WIDTH = 14;

   // One command frame as delivered by the bus receiver.
   typedef struct packed
   {
      logic [7:0] data;
      logic [3:0] addr;
      logic [3:0] code;
      logic [3:0] crc;
      logic is_long;
      logic from_upstream;
   } cmd_type;

   // One response frame handed to the bus transmitter.
   typedef struct packed
   {
      logic [15:0] data;
      logic [3:0] crc;
   } resp_type;

   // Conditions reported by the analog monitors.
   typedef struct packed
   {
      logic bus_short;
      logic parity_fault;
      logic fuse_fault;
      logic undervoltage;
      logic ground_fault;
   } monitor_type;

   // Where the final low bits of a response come from.
   typedef enum logic [1:0] {RK_PLAIN, RK_FMT, RK_REG8, RK_REG4} resp_kind_type;

endpackage

// ===== rtl/check_code_gen.sv
`timescale 1ns/10ps
// ****************************************************************
// Four-bit check code over a sixteen-bit frame.
// ****************************************************************
module check_code_gen
   import sensor_bus_pkg::*;
#(
   parameter logic [3:0] POLY = CRC_POLY,
   parameter logic [3:0] SEED = CRC_SEED
)
(
   // Frame in, code out.
   input wire logic [15:0] frame,
   output logic [3:0] code
);

   // Serial shift, most significant bit first.
   function automatic logic [3:0] crc4(input logic [15:0] bits);
      logic [3:0] r;
      logic fb;
      r = SEED;
      for (int i = 15; i >= 0; i--)
      begin
         fb = r[3] ^ bits[i];
         r = {r[2:0], 1'b0};
         if (fb)
         begin
            r = r ^ POLY;
         end
      end
      return r;
   endfunction

   assign code = crc4(frame);

endmodule

// ===== rtl/format_reg_mem.sv
`timescale 1ns/10ps
// ****************************************************************
// Format control register file with registered read data.
// ****************************************************************
module format_reg_mem
#(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Write port.
   input wire logic write_en,
   input wire logic [$clog2(DEPTH)-1:0] write_addr,
   input wire logic [WIDTH-1:0] write_data,
   // Read port.
   input wire logic [$clog2(DEPTH)-1:0] read_addr,
   output logic [WIDTH-1:0] read_data
);

   logic [WIDTH-1:0] store [DEPTH];

   // Storage clears on reset so reads never return stale settings.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            store[i] <= '0;
         end
      end
      else if (write_en)
      begin
         store[write_addr] <= write_data;
      end
   end

   // Read data is a register; it shows the old word on a same-cycle write.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         read_data <= '0;
      end
      else
      begin
         read_data <= store[read_addr];
      end
   end

endmodule

// ===== rtl/sensor_bus_slave.sv
`timescale 1ns/10ps
// Function
// - Address from preset, else zero, assign if zero.
// - Attributes 10 unlocked, else config bits 1:0.
// - Latch bank pair; invalid pair gets no response.
// - Bus fault bit reports initialization bus test.
// - Switch bit requests closure, response shows state.
// - Three-bit format address picks one of eight.
// - Ground fault only when detection enabled.
// - Program enable bit enables one-time writes.
// - Memory command writes or reads low four bits.
// - Format write on 1, read on 0 unless global.
// - Status flag ORs all error conditions; the code leaves bus_short out of it.
// - Self-test bit shows stimulus state.
// - Enhanced features locked until init and format set.
// - Forward initialization accepted only from upstream input, reverse only from downstream.
// - Test downstream short; close switch if clean.
// - Ignore bus level about 180 us after closure.
// - Programmed: both addresses match; else command zero.
// - Failed addressing: no address, switch open, silent.
// - Init response layout with address twice.
// - Ignore initialization assigning address zero.
// - Undervoltage flag follows supply monitor.
module sensor_bus_slave
   import sensor_bus_pkg::*;
#(
   parameter int BLANK_COUNT = BLANK_CYCLES,
   parameter logic [3:0] BANK_OK_MASK = BANK_VALID_MASK
)
(
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Command from the bus receiver.
   input wire logic cmd_valid,
   input wire cmd_type cmd,
   // Device straps, monitors and configuration.
   input wire logic [3:0] otp_address,
   input wire monitor_type monitors,
   input wire logic ground_loss_detect_enable,
   input wire logic config_lock_bit,
   input wire logic [1:0] device_config_one,
   input wire logic [9:0] accel_result,
   input wire logic [7:0] user_reg_data,
   // Response to the bus transmitter.
   output logic resp_valid,
   output resp_type resp,
   // Device state.
   output logic [3:0] node_address,
   output logic bus_switch_closed,
   output logic bus_fault_flag,
   output logic program_enable_bit,
   output logic [1:0] bank_sel,
   output logic bus_level_ignore,
   output logic selftest_enable,
   output logic enhanced_mode,
   // User register and one-time memory access.
   output logic [3:0] user_reg_addr,
   output logic otp_write,
   output logic [3:0] otp_write_data
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Bank pair validity lookup.
   function automatic logic bank_ok(input logic [1:0] pair);
      return BANK_OK_MASK[pair];
   endfunction

   logic initialized;
   logic fmt_configured;
   logic [BLANK_WIDTH-1:0] blank_count;
   logic stage_valid;
   logic [15:0] stage_data;
   resp_kind_type stage_kind;
   logic [3:0] cmd_code_calc;
   logic [15:0] next_resp_data;
   logic [3:0] next_resp_crc;
   logic [FMT_WIDTH-1:0] fmt_rdata;
   logic crc_ok;
   logic taken;
   logic init_cmd;
   logic addr_ok;
   logic init_ok;
   logic addressed;
   logic short_refused;
   logic gf_bit;
   logic s_bit;
   logic [1:0] attr_bits;
   logic [7:0] status_bits;
   logic fmt_write;
   logic [3:0] new_addr;

   // ****************************************************************
   // Command qualification
   // ****************************************************************

   // Check code over data, address and command fields.
   check_code_gen #(.POLY(CRC_POLY), .SEED(CRC_SEED)) cmd_check
   (
      .frame({cmd.data, cmd.addr, cmd.code}),
      .code(cmd_code_calc)
   );

   assign new_addr = cmd.data[3:0];
   assign crc_ok = cmd_code_calc == cmd.crc;
   // Short frames belong to the enhanced protocol and wait for it.
   assign short_refused = !cmd.is_long && !enhanced_mode;
   assign taken = cmd_valid && crc_ok && !short_refused;
   // Forward initialization only upstream, reverse only downstream.
   assign init_cmd = (cmd.code == CMD_INIT && cmd.from_upstream) ||
                     (cmd.code == CMD_REV_INIT && !cmd.from_upstream);
   // An unassigned device takes the new address; otherwise both must match.
   assign addr_ok = (node_address == NO_ADDR) ? (cmd.addr == NO_ADDR) :
                    (cmd.addr == node_address && new_addr == node_address);
   assign init_ok = taken && init_cmd && cmd.is_long && new_addr != NO_ADDR &&
                    bank_ok(cmd.data[5:4]) && addr_ok;
   assign addressed = taken && initialized && cmd.addr == node_address;
   assign fmt_write = taken && initialized && cmd.code == CMD_FORMAT && cmd.data[RW_POS] &&
                      (cmd.addr == node_address || cmd.addr == GLOBAL_ADDR);

   // ****************************************************************
   // Status word
   // ****************************************************************

   // Ground fault is masked when detection is off.
   assign gf_bit = ground_loss_detect_enable && monitors.ground_fault;
   assign s_bit = selftest_enable || monitors.parity_fault || monitors.fuse_fault ||
                  monitors.undervoltage || gf_bit;
   assign attr_bits = config_lock_bit ? device_config_one : ATTR_UNLOCKED;
   assign status_bits = {program_enable_bit, monitors.undervoltage, selftest_enable,
                         bus_switch_closed, attr_bits, s_bit, gf_bit};

   // ****************************************************************
   // Initialization state
   // ****************************************************************

   // The preset address is caught while reset is held.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         node_address <= otp_address;
         initialized <= 1'b0;
      end
      else if (init_ok)
      begin
         node_address <= new_addr;
         initialized <= 1'b1;
      end
   end

   // Bus test result, switch and latched command bits.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         bus_fault_flag <= 1'b0;
         bus_switch_closed <= 1'b0;
         program_enable_bit <= 1'b0;
         bank_sel <= 2'b00;
      end
      else if (init_ok)
      begin
         bus_fault_flag <= monitors.bus_short;
         bus_switch_closed <= cmd.data[BS_POS] && !monitors.bus_short;
         program_enable_bit <= cmd.data[NV_POS];
         bank_sel <= cmd.data[5:4];
      end
      else if (taken && init_cmd)
      begin
         bus_switch_closed <= 1'b0;
      end
   end

   // Blanking lets a downstream slave charge its hold capacitor.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         blank_count <= '0;
         bus_level_ignore <= 1'b0;
      end
      else if (init_ok && cmd.data[BS_POS])
      begin
         blank_count <= BLANK_WIDTH'(BLANK_COUNT - 1);
         bus_level_ignore <= 1'b1;
      end
      else if (blank_count != '0)
      begin
         blank_count <= blank_count - 1'b1;
      end
      else
      begin
         bus_level_ignore <= 1'b0;
      end
   end

   // ****************************************************************
   // Mode, self-test and memory access
   // ****************************************************************

   // Enhanced mode needs an initialization plus a format setting.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         fmt_configured <= 1'b0;
         enhanced_mode <= 1'b0;
      end
      else
      begin
         if (fmt_write)
         begin
            fmt_configured <= 1'b1;
         end
         enhanced_mode <= initialized && fmt_configured;
      end
   end

   // Self-test stimulus follows its two commands.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         selftest_enable <= 1'b0;
      end
      else if (addressed && cmd.code == CMD_ST_ON)
      begin
         selftest_enable <= 1'b1;
      end
      else if (addressed && cmd.code == CMD_ST_OFF)
      begin
         selftest_enable <= 1'b0;
      end
   end

   // One-time writes only happen with programming enabled.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         otp_write <= 1'b0;
         otp_write_data <= 4'h0;
         user_reg_addr <= 4'h0;
      end
      else
      begin
         otp_write <= addressed && cmd.code == CMD_NVM && program_enable_bit;
         if (addressed && (cmd.code == CMD_NVM || cmd.code == CMD_REG_READ))
         begin
            user_reg_addr <= cmd.data[7:4];
            otp_write_data <= cmd.data[3:0];
         end
      end
   end

   // Format registers; read address taken straight from the command.
   format_reg_mem #(.WIDTH(FMT_WIDTH), .DEPTH(FMT_DEPTH)) fmt_mem
   (
      .clock(clock),
      .reset(reset),
      .write_en(fmt_write),
      .write_addr(cmd.data[6:4]),
      .write_data(cmd.data[3:0]),
      .read_addr(cmd.data[6:4]),
      .read_data(fmt_rdata)
   );

   // ****************************************************************
   // Response assembly
   // ****************************************************************

   // First stage builds the frame; late fields are filled in next cycle.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         stage_valid <= 1'b0;
         stage_data <= 16'h0000;
         stage_kind <= RK_PLAIN;
      end
      else
      begin
         stage_valid <= 1'b0;
         stage_kind <= RK_PLAIN;
         if (init_ok)
         begin
            stage_valid <= 1'b1;
            stage_data <= {new_addr, 3'b000, monitors.bus_short, cmd.data[NV_POS],
                           cmd.data[BS_POS] && !monitors.bus_short, cmd.data[5:4], new_addr};
         end
         else if (addressed)
         begin
            case (cmd.code)
               CMD_STATUS, CMD_ST_OFF, CMD_ST_ON:
               begin
                  stage_valid <= 1'b1;
                  stage_data <= {node_address, 4'h0, status_bits};
               end
               CMD_ACCEL:
               begin
                  stage_valid <= 1'b1;
                  stage_data <= {node_address, gf_bit, s_bit, accel_result};
               end
               CMD_NVM:
               begin
                  stage_valid <= 1'b1;
                  stage_data <= {node_address, cmd.data[7:4], 4'h0, cmd.data[3:0]};
                  stage_kind <= program_enable_bit ? RK_PLAIN : RK_REG4;
               end
               CMD_REG_READ:
               begin
                  stage_valid <= 1'b1;
                  stage_data <= {node_address, cmd.data[7:4], 8'h00};
                  stage_kind <= RK_REG8;
               end
               CMD_FORMAT:
               begin
                  stage_valid <= 1'b1;
                  stage_data <= {node_address, FORMAT_ECHO, cmd.data};
                  stage_kind <= cmd.data[RW_POS] ? RK_PLAIN : RK_FMT;
               end
               default:
               begin
                  stage_valid <= 1'b0;
               end
            endcase
         end
      end
   end

   // Late fields: format and user register data arrive one cycle later.
   always_comb
   begin
      case (stage_kind)
         RK_FMT: next_resp_data = {stage_data[15:4], fmt_rdata};
         RK_REG8: next_resp_data = {stage_data[15:8], user_reg_data};
         RK_REG4: next_resp_data = {stage_data[15:4], user_reg_data[3:0]};
         default: next_resp_data = stage_data;
      endcase
   end

   check_code_gen #(.POLY(CRC_POLY), .SEED(CRC_SEED)) resp_check
   (
      .frame(next_resp_data),
      .code(next_resp_crc)
   );

   // Output stage; every response is a one-cycle pulse.
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         resp_valid <= 1'b0;
         resp <= '0;
      end
      else
      begin
         resp_valid <= stage_valid;
         if (stage_valid)
         begin
            resp <= '{data: next_resp_data, crc: next_resp_crc};
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   a_addr_preset: assert property ($past(reset) && !reset |-> node_address == $past(otp_address))
      else $error("address not loaded from preset");
   a_attr_unlocked: assert property (addressed && cmd.code == CMD_STATUS && !config_lock_bit
                                     |-> ##2 resp_valid && resp.data[3:2] == 2'b10)
      else $error("attribute code wrong while unlocked");
   a_bank_refused: assert property (taken && init_cmd && !bank_ok(cmd.data[5:4]) && !initialized
                                    |-> ##2 !resp_valid)
      else $error("response to invalid bank pair");
   a_fault_report: assert property (init_ok |=> bus_fault_flag == $past(monitors.bus_short))
      else $error("bus fault flag mismatch");
   a_switch_close: assert property (init_ok |=> bus_switch_closed ==
                                    ($past(cmd.data[BS_POS]) && !$past(monitors.bus_short)))
      else $error("switch state wrong after init");
   a_ground_gated: assert property (addressed && cmd.code == CMD_STATUS && !ground_loss_detect_enable
                                    |-> ##2 !resp.data[0])
      else $error("ground fault shown while detection off");
   a_blank_hold: assert property (init_ok && cmd.data[BS_POS] |=> bus_level_ignore [*8])
      else $error("bus level blanking too short");
   a_upstream_only: assert property (cmd_valid && cmd.code == CMD_INIT && !cmd.from_upstream
                                     |-> !init_ok ##2 !resp_valid)
      else $error("initialization taken from downstream");
   a_zero_ignored: assert property (cmd_valid && init_cmd && new_addr == NO_ADDR
                                    |=> $stable(node_address))
      else $error("address zero assigned");
   a_init_layout: assert property (init_ok |-> ##2 resp_valid && resp.data[15:12] == resp.data[3:0]
                                   && resp.data[11:9] == 3'b000)
      else $error("init response layout wrong");

   c_init_done: cover property (init_ok ##2 resp_valid);
   c_format_read: cover property (addressed && cmd.code == CMD_FORMAT && !cmd.data[RW_POS] ##2 resp_valid);
   c_status_read: cover property (addressed && cmd.code == CMD_STATUS ##2 resp_valid);

endmodule

// ===== sim/bus_master_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Bus master controller model: frames commands for the slave.
// ****************************************************************
module bus_master_model
   import sensor_bus_pkg::*;
(
   // Clock.
   input wire logic clock,
   // Command toward the slave.
   output logic cmd_valid,
   output cmd_type cmd
);
   // Lines start quiet.
   initial
   begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // Check code over a sixteen-bit word, most significant bit first.
   function automatic logic [3:0] crc16(input logic [15:0] w);
      logic [3:0] c;
      c = CRC_SEED;
      for (int i = 15; i >= 0; i--)
      begin
         c = {c[2:0], 1'b0} ^ ((c[3] ^ w[i]) ? CRC_POLY : 4'h0);
      end
      return c;
   endfunction

   // One frame for exactly one edge; bad spoils the check code.
   // Afterwards the lines show the inverse frame, so stale data never looks current.
   task automatic send(input logic [7:0] d, input logic [3:0] a, input logic [3:0] c, input logic lg,
                       input logic up, input logic bad);
      @(posedge clock);
      #1;
      cmd.data = d;
      cmd.addr = a;
      cmd.code = c;
      cmd.crc = crc16({d, a, c}) ^ {3'b000, bad};
      cmd.is_long = lg;
      cmd.from_upstream = up;
      cmd_valid = 1'b1;
      @(posedge clock);
      #1;
      cmd_valid = 1'b0;
      cmd = ~cmd;
   endtask
endmodule

// ===== sim/sensor_bus_slave_tb.sv
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the sensor bus slave.
// ****************************************************************
module sensor_bus_slave_tb;
   import sensor_bus_pkg::*;
   // Short blanking keeps the run brief.
   localparam int BLANK = 20;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid;
   cmd_type cmd;
   logic [3:0] otp_address = 4'h0;
   monitor_type mon = '0;
   logic gld = 1'b0;
   logic lock = 1'b0;
   logic [1:0] cfg = 2'b00;
   logic [9:0] accel = 10'h000;
   logic [7:0] rdata = 8'h00;
   logic resp_valid, bus_switch_closed, bus_fault_flag, program_enable_bit, bus_level_ignore;
   logic selftest_enable, enhanced_mode, otp_write;
   resp_type resp, rsp;
   logic [3:0] node_address, user_reg_addr, otp_write_data, wdat, na, ra, fd;
   logic [1:0] bank_sel, bank;
   logic st, gf, s;
   logic [3:0] fmt [8];
   int failures = 0;
   int cmp_count = 0;
   int seed = 21358;
   int got, wcnt;

   // Clock.
   always #10 clock = ~clock;

   bus_master_model master (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd));

   sensor_bus_slave #(.BLANK_COUNT(BLANK)) uut (.clock(clock), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
      .otp_address(otp_address), .monitors(mon), .ground_loss_detect_enable(gld), .config_lock_bit(lock),
      .device_config_one(cfg), .accel_result(accel), .user_reg_data(rdata), .resp_valid(resp_valid),
      .resp(resp), .node_address(node_address), .bus_switch_closed(bus_switch_closed),
      .bus_fault_flag(bus_fault_flag), .program_enable_bit(program_enable_bit), .bank_sel(bank_sel),
      .bus_level_ignore(bus_level_ignore), .selftest_enable(selftest_enable), .enhanced_mode(enhanced_mode),
      .user_reg_addr(user_reg_addr), .otp_write(otp_write), .otp_write_data(otp_write_data));

   // One comparison, counted.
   task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] seen);
      cmp_count++;
      if (exp !== seen)
      begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Sends a frame, then watches four cycles from just after the taking edge, so one-cycle strobes are seen.
   // A response in the wrong cycle counts ten.
   task automatic xact(input logic [7:0] d, input logic [3:0] a, input logic [3:0] c, input logic lg,
                       input logic up, input logic bad);
      got = 0;
      wcnt = 0;
      master.send(d, a, c, lg, up, bad);
      for (int i = 0; i < 4; i++)
      begin
         if (resp_valid === 1'b1)
         begin
            got += (i == 1) ? 1 : 10;
            rsp = resp;
         end
         if (otp_write === 1'b1)
         begin
            wcnt++;
            wdat = otp_write_data;
         end
         @(posedge clock);
         #1;
      end
   endtask

   // Exactly one response, data and check code as expected.
   task automatic want(input string name, input logic [15:0] d);
      chk(name, 1, got);
      chk(name, {d, master.crc16(d)}, rsp);
   endtask

   // Expected initialization answer.
   function automatic logic [15:0] init_word(input logic bf, input logic nv, input logic bs);
      return {na, 3'b000, bf, nv, bs, bank, na};
   endfunction

   // Verdict and end of run.
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Cuts a hang short.
   initial
   begin
      #100000;
      failures++;
      stop_test();
   end

   // Main sequence.
   initial
   begin
      repeat (2) @(posedge clock);
      #1;
      reset = 1'b0;
      chk("node_address", 4'h0, node_address);
      na = 4'(1 + (($random(seed) & 32'hff) % 15));
      bank = 2'(($random(seed) & 32'hff) % 3);
      xact(8'h05, 4'h5, CMD_STATUS, 1'b1, 1'b1, 1'b0);
      chk("status before init", 0, got);
      xact({4'h4, na}, 4'h0, CMD_INIT, 1'b0, 1'b1, 1'b0);
      chk("short init", 0, got);
      xact({4'h4, na}, 4'h0, CMD_INIT, 1'b1, 1'b0, 1'b0);
      chk("downstream init", 0, got);
      xact({4'h4, na}, 4'h0, CMD_INIT, 1'b1, 1'b1, 1'b1);
      chk("bad check code", 0, got);
      xact(8'h40, 4'h0, CMD_INIT, 1'b1, 1'b1, 1'b0);
      chk("address zero", 0, got);
      xact({4'h7, na}, 4'h0, CMD_INIT, 1'b1, 1'b1, 1'b0);
      chk("invalid bank", 0, got);
      xact({2'b01, bank, na}, na, CMD_INIT, 1'b1, 1'b1, 1'b0);
      chk("address mismatch", 0, got);
      chk("node_address", 4'h0, node_address);
      chk("bus_switch_closed", 0, bus_switch_closed);
      // Bus short on the downstream node keeps the switch open.
      mon.bus_short = 1'b1;
      xact({2'b01, bank, na}, 4'h0, CMD_INIT, 1'b1, 1'b1, 1'b0);
      want("init with short", init_word(1'b1, 1'b0, 1'b0));
      chk("fault and switch", 2'b10, {bus_fault_flag, bus_switch_closed});
      mon.bus_short = 1'b0;
      xact({2'b11, bank, na}, na, CMD_INIT, 1'b1, 1'b1, 1'b0);
      want("reinit", init_word(1'b0, 1'b1, 1'b1));
      chk("state", {na, bank, 2'b11}, {node_address, bank_sel, program_enable_bit, bus_switch_closed});
      chk("bus_level_ignore", 1, bus_level_ignore);
      repeat (BLANK - 5) @(posedge clock);
      #1;
      chk("bus_level_ignore", 1, bus_level_ignore);
      repeat (10) @(posedge clock);
      #1;
      chk("bus_level_ignore", 0, bus_level_ignore);
      // Every lock and configuration pair, random monitors, self-test toggled midway.
      st = 1'b0;
      for (int k = 0; k < 8; k++)
      begin
         if (k == 4 || k == 6)
         begin
            st = (k == 4);
            xact(8'h00, na, st ? CMD_ST_ON : CMD_ST_OFF, 1'b1, 1'b1, 1'b0);
            chk("selftest_enable", st, selftest_enable);
         end
         lock = k[2];
         cfg = k[1:0];
         gld = 1'($random(seed));
         mon = monitor_type'(5'($random(seed)));
         mon.bus_short = 1'b0;
         accel = 10'($random(seed));
         gf = gld & mon.ground_fault;
         s = st | mon.parity_fault | mon.fuse_fault | mon.undervoltage | gf;
         xact(8'($random(seed)), na, CMD_STATUS, 1'b1, 1'b1, 1'b0);
         want("status", {na, 5'h01, mon.undervoltage, st, 1'b1, lock ? cfg : 2'b10, s, gf});
         xact(8'h00, na, CMD_ACCEL, 1'b1, 1'b1, 1'b0);
         want("acceleration", {na, gf, s, accel});
      end
      // All eight format registers written, then read back.
      for (int i = 0; i < 8; i++)
      begin
         fmt[i] = 4'($random(seed));
         xact({1'b1, 3'(i), fmt[i]}, na, CMD_FORMAT, 1'b1, 1'b1, 1'b0);
      end
      chk("enhanced_mode", 1, enhanced_mode);
      for (int i = 0; i < 8; i++)
      begin
         xact({1'b0, 3'(i), 4'h0}, na, CMD_FORMAT, 1'b1, 1'b1, 1'b0);
         want("format read", {na, 4'h6, 1'b0, 3'(i), fmt[i]});
      end
      xact(8'h00, GLOBAL_ADDR, CMD_FORMAT, 1'b1, 1'b1, 1'b0);
      chk("global format read", 0, got);
      ra = 4'($random(seed));
      rdata = 8'($random(seed));
      xact({ra, 4'h0}, na, CMD_REG_READ, 1'b1, 1'b1, 1'b0);
      want("register read", {na, ra, rdata});
      chk("user_reg_addr", ra, user_reg_addr);
      fd = 4'($random(seed));
      xact({ra, fd}, na, CMD_NVM, 1'b1, 1'b1, 1'b0);
      chk("otp write", {4'h1, fd}, {wcnt[3:0], wdat});
      // Programming disabled by a fresh initialization.
      xact({2'b01, bank, na}, na, CMD_INIT, 1'b1, 1'b1, 1'b0);
      want("reinit", init_word(1'b0, 1'b0, 1'b1));
      xact({ra, fd}, na, CMD_NVM, 1'b1, 1'b1, 1'b0);
      chk("otp write pulses", 0, wcnt);
      want("otp read", {na, ra, 4'h0, rdata[3:0]});
      // Reverse initialization arrives from the downstream side.
      xact({2'b01, bank, na}, na, CMD_REV_INIT, 1'b1, 1'b0, 1'b0);
      want("reverse init", init_word(1'b0, 1'b0, 1'b1));
      stop_test();
   end
endmodule
